// ### rtl/rx_err_selftest.sv
// receive-error counter, PRBS self-test control and loopback path select
// assumes rx/prbs status inputs are synchronous to sys_clk; register port per house bus
//
// Contract
// (RL1) count rx errors during valid carrier
// (RL2) no counting in MII loopback mode
// (RL3) counter saturates at FFh
// (RL4) interrupt event when count exceeds 7Fh
// (RL5) read returns count then clears it
// (RL6) single mode: BIST counter stops at max
// (RL7) continuous mode: pulse at max, restart
// (RL8) config 0 off, 1 single constant packet
// (RL9) config 2 checker only, 3 both continuous
// (RL10) lock bit shows checker lock
// (RL11) sync-loss bit shows lost sync
// (RL12) generator status bit shows generator active
// (RL13) power-mode bit, 1 normal, resets 1
// (RL14) tx-in-loopback also drives line at 100M
// (RL15) software sets tx-in-loopback only in loopback
// (RL16) loop select 1 PCS input, 2 PCS output
// (RL17) 4 digital, 8 analog, 16 reverse
// (RL18) half-full irq gated by enable bit 0
// (RL19) reserved control bits read zero
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module rx_err_selftest
    import selftest_pkg::*;
#(
    parameter int BIST_CNT_W = 16
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire logic rx_dv,
    input wire logic rx_carrier,
    input wire logic rx_symbol_err,
    input wire logic mii_loopback,
    input wire logic speed_100,
    input wire logic prbs_err,
    input wire logic prbs_locked,
    input wire logic prbs_sync_lost,
    input wire logic gen_active,
    input wire logic active_sleep,
    output logic gen_enable,
    output logic gen_continuous,
    output logic chk_enable,
    output logic chk_counting,
    output logic bist_wrap_pulse,
    output logic tx_to_line,
    output logic [4:0] loop_select,
    output logic irq
);
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [15:0] rx_err;
        logic [15:0] ctrl;
        logic [BIST_CNT_W-1:0] bist_cnt;
        logic bist_stopped;
        logic [2:0] irq_stat;
        logic [2:0] irq_en;
        logic [15:0] rdata;
        logic gen_en;
        logic gen_cont;
        logic chk_en;
        logic chk_cnt;
        logic wrap;
        logic tx_line;
        logic [4:0] lsel;
        logic irq;
    } state_t;

    state_t st_reg, st_next;

    // one-hot loop select values only; anything else disables loopback paths
    function automatic logic [4:0] loop_decode(input logic [4:0] f);
        unique case (f)
            LB_PCS_IN, LB_PCS_OUT, LB_DIGITAL, LB_ANALOG, LB_REVERSE: loop_decode = f;
            default: loop_decode = 5'h00;
        endcase
    endfunction

    logic rx_inc, rd_count, bist_max, half_cross;
    logic [15:0] status_word;

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        rd_count = reg_rd && (reg_addr == OFS_RX_ERR_COUNT);
        // a receive error in loopback is a test artefact, not a line error
        rx_inc = rx_dv && rx_carrier && rx_symbol_err && !mii_loopback; // [RL1] [RL2]
        half_cross = 1'b0;
        // read clears; a concurrent error is kept as a count of one
        if (rd_count) begin
            st_next.rx_err = rx_inc ? 16'h0001 : 16'h0000; // [RL5]
        end else if (rx_inc && st_reg.rx_err < RX_ERR_MAX) begin
            st_next.rx_err = st_reg.rx_err + 16'h0001; // [RL3]
            half_cross = (st_reg.rx_err == RX_ERR_HALF); // [RL4]
        end
        // live status bits overlay the stored control fields
        status_word = (st_reg.ctrl & CTRL_WRITE_MASK);
        status_word[BIT_LOCK] = prbs_locked; // [RL10]
        status_word[BIT_SYNC_LOSS] = prbs_sync_lost; // [RL11]
        status_word[BIT_GEN_STATUS] = gen_active; // [RL12]
        status_word[BIT_POWER_MODE] = !active_sleep; // [RL13]
        if (reg_wr && reg_addr == OFS_SELFTEST_CTRL) begin
            st_next.ctrl = (reg_wdata & CTRL_WRITE_MASK) | (CTRL_RESET & ~CTRL_WRITE_MASK); // [RL19]
            st_next.bist_cnt = '0;
            st_next.bist_stopped = 1'b0;
        end
        // BIST error counter
        bist_max = (st_reg.bist_cnt == {BIST_CNT_W{1'b1}});
        st_next.wrap = 1'b0;
        if (st_reg.chk_en && prbs_err && !st_reg.bist_stopped) begin
            if (bist_max) begin
                if (st_reg.ctrl[BIT_ERR_CNT_MODE]) begin
                    st_next.bist_cnt = '0; // [RL7]
                    st_next.wrap = 1'b1; // [RL7]
                end else begin
                    st_next.bist_stopped = 1'b1; // [RL6]
                end
            end else begin
                st_next.bist_cnt = st_reg.bist_cnt + BIST_CNT_W'(1);
            end
        end
        // generator / checker configuration decode
        unique case (st_reg.ctrl[13:12])
            GC_OFF: begin
                st_next.gen_en = 1'b0; // [RL8]
                st_next.chk_en = 1'b0;
                st_next.gen_cont = 1'b0;
            end
            GC_SINGLE: begin
                st_next.gen_en = 1'b1; // [RL8]
                st_next.chk_en = 1'b0;
                st_next.gen_cont = 1'b0;
            end
            GC_CHECK: begin
                st_next.gen_en = 1'b0; // [RL9]
                st_next.chk_en = 1'b1;
                st_next.gen_cont = 1'b0;
            end
            GC_BOTH: begin
                st_next.gen_en = 1'b1; // [RL9]
                st_next.chk_en = 1'b1;
                st_next.gen_cont = 1'b1;
            end
        endcase
        st_next.chk_cnt = st_next.chk_en && !st_next.bist_stopped;
        // parallel line transmit only meaningful with loopback at 100M
        st_next.tx_line = st_reg.ctrl[BIT_TX_IN_LOOP] && mii_loopback && speed_100; // [RL14] [RL15]
        st_next.lsel = loop_decode(st_reg.ctrl[4:0]); // [RL16] [RL17]
        // interrupts: set wins over clear
        if (reg_wr && reg_addr == OFS_IRQ_CLEAR) begin
            st_next.irq_stat = st_reg.irq_stat & ~reg_wdata[2:0];
        end
        if (reg_wr && reg_addr == OFS_IRQ_ENABLE) begin
            st_next.irq_en = reg_wdata[2:0];
        end
        if (half_cross) begin
            st_next.irq_stat[IRQ_RX_HALF] = 1'b1; // [RL4]
        end
        if (st_next.wrap) begin
            st_next.irq_stat[IRQ_BIST_WRAP] = 1'b1;
        end
        if (prbs_sync_lost) begin
            st_next.irq_stat[IRQ_SYNC_LOSS] = 1'b1;
        end
        st_next.irq = |(st_next.irq_stat & st_next.irq_en); // [RL18]
        // read data, one cycle after the strobe; unmapped reads zero
        st_next.rdata = 16'h0000;
        if (reg_rd) begin
            unique case (reg_addr)
                OFS_RX_ERR_COUNT: st_next.rdata = st_reg.rx_err;
                OFS_SELFTEST_CTRL: st_next.rdata = status_word;
                OFS_IRQ_STATUS: st_next.rdata = {13'h0000, st_reg.irq_stat};
                OFS_IRQ_ENABLE: st_next.rdata = {13'h0000, st_reg.irq_en};
                default: st_next.rdata = 16'h0000;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            st_reg <= '0;
            st_reg.ctrl <= CTRL_RESET; // [RL13]
        end else begin
            st_reg <= st_next;
        end
    end

    // outputs straight from flip-flops
    assign reg_rdata = st_reg.rdata;
    assign gen_enable = st_reg.gen_en;
    assign gen_continuous = st_reg.gen_cont;
    assign chk_enable = st_reg.chk_en;
    assign chk_counting = st_reg.chk_cnt;
    assign bist_wrap_pulse = st_reg.wrap;
    assign tx_to_line = st_reg.tx_line;
    assign loop_select = st_reg.lsel;
    assign irq = st_reg.irq;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    sequence s_err_seen;
        rx_dv && rx_carrier && rx_symbol_err && !mii_loopback && !rd_count && st_reg.rx_err < RX_ERR_MAX;
    endsequence
    property p_rx_count;
        @(posedge sys_clk) disable iff (!rst_n) s_err_seen |=> st_reg.rx_err == $past(st_reg.rx_err) + 16'h0001;
    endproperty
    a_rx_count: assert property (p_rx_count) else $error("rx error not counted"); // [RL1]
    property p_loop_hold;
        @(posedge sys_clk) disable iff (!rst_n) (mii_loopback && !rd_count) |=> $stable(st_reg.rx_err);
    endproperty
    a_loop_hold: assert property (p_loop_hold) else $error("counted in loopback"); // [RL2]
    property p_sat;
        @(posedge sys_clk) disable iff (!rst_n) st_reg.rx_err <= RX_ERR_MAX;
    endproperty
    a_sat: assert property (p_sat) else $error("rx counter past max"); // [RL3]
    property p_half;
        @(posedge sys_clk) disable iff (!rst_n)
            (st_reg.rx_err == RX_ERR_HALF && rx_inc && !rd_count) |=> st_reg.irq_stat[IRQ_RX_HALF];
    endproperty
    a_half: assert property (p_half) else $error("half-full event missed"); // [RL4]
    property p_rd_clear;
        @(posedge sys_clk) disable iff (!rst_n)
            rd_count |=> (reg_rdata == $past(st_reg.rx_err)) && (st_reg.rx_err <= 16'h0001);
    endproperty
    a_rd_clear: assert property (p_rd_clear) else $error("clear on read failed"); // [RL5]
    property p_wrap;
        @(posedge sys_clk) disable iff (!rst_n)
            (st_reg.chk_en && prbs_err && bist_max && !st_reg.bist_stopped && st_reg.ctrl[BIT_ERR_CNT_MODE]
             && !(reg_wr && reg_addr == OFS_SELFTEST_CTRL)) |=> bist_wrap_pulse ##1 !bist_wrap_pulse;
    endproperty
    a_wrap: assert property (p_wrap) else $error("continuous wrap pulse wrong"); // [RL7]
    property p_mode3;
        @(posedge sys_clk) disable iff (!rst_n) (st_reg.ctrl[13:12] == GC_BOTH) |=> gen_continuous && chk_enable;
    endproperty
    a_mode3: assert property (p_mode3) else $error("config 3 decode wrong"); // [RL9]
    property p_irq;
        @(posedge sys_clk) disable iff (!rst_n) irq |-> |(st_reg.irq_stat & st_reg.irq_en);
    endproperty
    a_irq: assert property (p_irq) else $error("irq without enabled status"); // [RL18]

    // ----------------------------------------------------------------
    // assertions: reset and counter end points
    // ----------------------------------------------------------------
    // reset is synchronous, so its values show one edge after it is sampled low
    property p_reset;
        @(posedge sys_clk) !rst_n |=> (st_reg.ctrl == CTRL_RESET) && !irq && (reg_rdata == 16'h0000);
    endproperty
    a_reset: assert property (p_reset) else $error("reset values wrong"); // [RL13]
    // a full counter must hold even while errors keep arriving
    property p_hold_max;
        @(posedge sys_clk) disable iff (!rst_n)
            (st_reg.rx_err == RX_ERR_MAX && !rd_count) |=> st_reg.rx_err == RX_ERR_MAX;
    endproperty
    a_hold_max: assert property (p_hold_max) else $error("rx counter wrapped"); // [RL3]
    // an enabled half-full event must reach the pin, not only the status bit
    sequence s_half_enabled;
        half_cross && st_reg.irq_en[IRQ_RX_HALF] && !(reg_wr && reg_addr == OFS_IRQ_ENABLE);
    endsequence
    property p_irq_half;
        @(posedge sys_clk) disable iff (!rst_n) s_half_enabled |=> st_reg.irq_stat[IRQ_RX_HALF] && irq;
    endproperty
    a_irq_half: assert property (p_irq_half) else $error("enabled half-full irq missing"); // [RL18]

    // ----------------------------------------------------------------
    // assertions: BIST counter and configuration decode
    // ----------------------------------------------------------------
    // last error seen by a full BIST counter, no control write beside it
    sequence s_bist_full_err;
        st_reg.chk_en && prbs_err && bist_max && !st_reg.bist_stopped
            && !(reg_wr && reg_addr == OFS_SELFTEST_CTRL);
    endsequence
    // single mode: counter freezes, checker reports it stopped, no pulse
    property p_single_stop;
        @(posedge sys_clk) disable iff (!rst_n)
            s_bist_full_err ##0 !st_reg.ctrl[BIT_ERR_CNT_MODE]
            |=> st_reg.bist_stopped && !chk_counting && !bist_wrap_pulse;
    endproperty
    a_single_stop: assert property (p_single_stop) else $error("single mode did not stop"); // [RL6]
    // continuous mode: counter restarts from zero beside the pulse
    property p_restart;
        @(posedge sys_clk) disable iff (!rst_n)
            s_bist_full_err ##0 st_reg.ctrl[BIT_ERR_CNT_MODE] |=> (st_reg.bist_cnt == '0) && bist_wrap_pulse;
    endproperty
    a_restart: assert property (p_restart) else $error("continuous mode did not restart"); // [RL7]
    // each configuration code gives its own enables one cycle later
    property p_mode0;
        @(posedge sys_clk) disable iff (!rst_n)
            (st_reg.ctrl[13:12] == GC_OFF) |=> !gen_enable && !chk_enable;
    endproperty
    a_mode0: assert property (p_mode0) else $error("config 0 decode wrong"); // [RL8]
    property p_mode1;
        @(posedge sys_clk) disable iff (!rst_n)
            (st_reg.ctrl[13:12] == GC_SINGLE) |=> gen_enable && !gen_continuous && !chk_enable;
    endproperty
    a_mode1: assert property (p_mode1) else $error("config 1 decode wrong"); // [RL8]
    property p_mode2;
        @(posedge sys_clk) disable iff (!rst_n)
            (st_reg.ctrl[13:12] == GC_CHECK) |=> !gen_enable && chk_enable;
    endproperty
    a_mode2: assert property (p_mode2) else $error("config 2 decode wrong"); // [RL9]

    // ----------------------------------------------------------------
    // assertions: control read-back and path selects
    // ----------------------------------------------------------------
    sequence s_ctrl_read;
        reg_rd && reg_addr == OFS_SELFTEST_CTRL;
    endsequence
    // status bits are live levels, so a read shows what stood at the strobe
    property p_live_bits;
        @(posedge sys_clk) disable iff (!rst_n)
            s_ctrl_read |=> (reg_rdata[BIT_LOCK] == $past(prbs_locked))
                && (reg_rdata[BIT_SYNC_LOSS] == $past(prbs_sync_lost))
                && (reg_rdata[BIT_GEN_STATUS] == $past(gen_active))
                && (reg_rdata[BIT_POWER_MODE] == !$past(active_sleep));
    endproperty
    a_live_bits: assert property (p_live_bits) else $error("status bits wrong"); // [RL10] [RL11] [RL12] [RL13]
    // bits that are neither writable nor live status must read zero
    property p_reserved;
        @(posedge sys_clk) disable iff (!rst_n)
            s_ctrl_read |=> (reg_rdata & ~CTRL_WRITE_MASK & ~(16'h000F << BIT_POWER_MODE)) == 16'h0000;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bits not zero"); // [RL19]
    property p_tx_on;
        @(posedge sys_clk) disable iff (!rst_n)
            (st_reg.ctrl[BIT_TX_IN_LOOP] && mii_loopback && speed_100) |=> tx_to_line;
    endproperty
    a_tx_on: assert property (p_tx_on) else $error("line copy missing"); // [RL14]
    // outside loopback at 100M the line copy stays off whatever the bit says
    property p_tx_off;
        @(posedge sys_clk) disable iff (!rst_n) !(mii_loopback && speed_100) |=> !tx_to_line;
    endproperty
    a_tx_off: assert property (p_tx_off) else $error("line copy outside loopback"); // [RL14]
    // at most one loopback path may ever be selected
    property p_loop_legal;
        @(posedge sys_clk) disable iff (!rst_n) $onehot0(loop_select);
    endproperty
    a_loop_legal: assert property (p_loop_legal) else $error("several loop paths"); // [RL16] [RL17]
    property p_loop_pcs_in;
        @(posedge sys_clk) disable iff (!rst_n) (st_reg.ctrl[4:0] == LB_PCS_IN) |=> loop_select == LB_PCS_IN;
    endproperty
    a_loop_pcs_in: assert property (p_loop_pcs_in) else $error("PCS input loop not selected"); // [RL16]
    property p_loop_reverse;
        @(posedge sys_clk) disable iff (!rst_n) (st_reg.ctrl[4:0] == LB_REVERSE) |=> loop_select == LB_REVERSE;
    endproperty
    a_loop_reverse: assert property (p_loop_reverse) else $error("reverse loop not selected"); // [RL17]
endmodule // rx_err_selftest
`default_nettype wire

// ### rtl/selftest_pkg.sv
// constants for the receive-error counter and self-test / loopback control block
// assumes register offsets are word indices on the plain register port
package selftest_pkg;
    // ----------------------------------------------------------------
    // register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_RX_ERR_COUNT = 8'h15;
    localparam logic [7:0] OFS_SELFTEST_CTRL = 8'h16;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h18;
    localparam logic [7:0] OFS_IRQ_ENABLE = 8'h19;
    localparam logic [7:0] OFS_IRQ_CLEAR = 8'h1A;
    // ----------------------------------------------------------------
    // field positions and values
    // ----------------------------------------------------------------
    localparam int BIT_ERR_CNT_MODE = 14;
    localparam int BIT_LOCK = 11;
    localparam int BIT_SYNC_LOSS = 10;
    localparam int BIT_GEN_STATUS = 9;
    localparam int BIT_POWER_MODE = 8;
    localparam int BIT_TX_IN_LOOP = 6;
    localparam logic [15:0] CTRL_WRITE_MASK = 16'h705F;
    localparam logic [15:0] CTRL_RESET = 16'h0100;
    localparam logic [15:0] RX_ERR_MAX = 16'h00FF;
    localparam logic [15:0] RX_ERR_HALF = 16'h007F;
    localparam logic [1:0] GC_OFF = 2'h0;
    localparam logic [1:0] GC_SINGLE = 2'h1;
    localparam logic [1:0] GC_CHECK = 2'h2;
    localparam logic [1:0] GC_BOTH = 2'h3;
    localparam logic [4:0] LB_PCS_IN = 5'h01;
    localparam logic [4:0] LB_PCS_OUT = 5'h02;
    localparam logic [4:0] LB_DIGITAL = 5'h04;
    localparam logic [4:0] LB_ANALOG = 5'h08;
    localparam logic [4:0] LB_REVERSE = 5'h10;
    localparam int IRQ_RX_HALF = 0;
    localparam int IRQ_BIST_WRAP = 1;
    localparam int IRQ_SYNC_LOSS = 2;
endpackage

// ### verification/mac_rx_source.sv
// MAC-side receive source: bursts of symbol errors inside a carrier frame
// assumes start is a one-cycle request on sys_clk while busy is low
`timescale 1ns/1ps
`default_nettype none
module mac_rx_source (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic start,
    input wire logic [9:0] n_err,
    input wire logic slow,
    output logic rx_dv,
    output logic rx_carrier,
    output logic rx_symbol_err,
    output logic busy
);
    logic [9:0] left_reg;
    logic gap_reg;
    logic tog_reg;
    // slow mode leaves a clean cycle between errors; outside frames the error line toggles
    always_ff @(posedge sys_clk) begin
        gap_reg <= rst_n & slow & ~gap_reg;
        tog_reg <= ~tog_reg & rst_n;
        if (!rst_n) begin
            left_reg <= 10'h000;
        end else if (start) begin
            left_reg <= n_err;
        end else if (busy && !gap_reg) begin
            left_reg <= left_reg - 10'h001;
        end
    end
    assign busy = (left_reg != 10'h000);
    assign rx_dv = busy;
    assign rx_carrier = busy;
    assign rx_symbol_err = busy ? ~gap_reg : tog_reg;
endmodule // mac_rx_source
`default_nettype wire

// ### verification/rx_err_selftest_test.sv
// self-checking bench for rx_err_selftest with a MAC receive source
// assumes selftest_pkg and both modules are compiled first
`timescale 1ns/1ps
`default_nettype none
module rx_err_selftest_test;
    import selftest_pkg::*;
    logic sys_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, start = 1'b0, slow = 1'b0;
    logic mii_loopback = 1'b0, speed_100 = 1'b0, prbs_err = 1'b0, prbs_locked = 1'b0;
    logic prbs_sync_lost = 1'b0, gen_active = 1'b0, active_sleep = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata, d;
    logic [9:0] n_err = 10'h000;
    logic rx_dv, rx_carrier, rx_symbol_err, busy, gen_enable, gen_continuous, chk_enable;
    logic chk_counting, bist_wrap_pulse, tx_to_line, irq;
    logic [4:0] loop_select;
    logic [4:0] lb[6] = '{LB_PCS_IN, LB_PCS_OUT, LB_DIGITAL, LB_ANALOG, LB_REVERSE, 5'h03};
    int fails = 0, cmp_count = 0, rx_cnt = 0, half = 0, pulses = 0, i, n;
    logic [31:0] r;

    // ----------------------------------------------------------------
    // clock, design and far side
    // ----------------------------------------------------------------
    always #25 sys_clk = ~sys_clk;
    // pulses are counted mid-cycle, away from the launching edge
    always @(negedge sys_clk) if (bist_wrap_pulse === 1'b1) pulses++;
    rx_err_selftest #(.BIST_CNT_W(4)) dut (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_dv(rx_dv),
        .rx_carrier(rx_carrier), .rx_symbol_err(rx_symbol_err), .mii_loopback(mii_loopback),
        .speed_100(speed_100), .prbs_err(prbs_err), .prbs_locked(prbs_locked),
        .prbs_sync_lost(prbs_sync_lost), .gen_active(gen_active), .active_sleep(active_sleep),
        .gen_enable(gen_enable), .gen_continuous(gen_continuous), .chk_enable(chk_enable),
        .chk_counting(chk_counting), .bist_wrap_pulse(bist_wrap_pulse), .tx_to_line(tx_to_line),
        .loop_select(loop_select), .irq(irq));
    mac_rx_source far (.sys_clk(sys_clk), .rst_n(rst_n), .start(start), .n_err(n_err), .slow(slow),
        .rx_dv(rx_dv), .rx_carrier(rx_carrier), .rx_symbol_err(rx_symbol_err), .busy(busy));

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] v);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [15:0] v);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask
    task automatic settle();
        repeat (2) @(posedge sys_clk);
        #1;
    endtask
    // model: saturating count, half-full event on crossing 7Fh, frozen in loopback
    task automatic errs(input int k);
        @(posedge sys_clk);
        n_err <= k[9:0];
        start <= 1'b1;
        @(posedge sys_clk);
        start <= 1'b0;
        for (int w = 0; w < 3000 && (busy !== 1'b0 || w < 1); w++) begin
            @(posedge sys_clk);
            #1;
        end
        if (busy !== 1'b0) begin
            fails++;
            summarize();
        end else if (!mii_loopback) begin
            if (rx_cnt <= 127 && rx_cnt + k > 127) half = 1;
            rx_cnt = (rx_cnt + k > 255) ? 255 : rx_cnt + k;
        end
    endtask
    task automatic perr(input int k);
        @(posedge sys_clk);
        prbs_err <= 1'b1;
        repeat (k) @(posedge sys_clk);
        prbs_err <= 1'b0;
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        void'($urandom(32'h83CEA518));
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        rd(OFS_SELFTEST_CTRL, d);
        chk(d, CTRL_RESET);
        wr(OFS_SELFTEST_CTRL, 16'hFFBF);
        rd(OFS_SELFTEST_CTRL, d);
        chk(d, (CTRL_WRITE_MASK & 16'hFFBF) | 16'h0100);
        rd(8'h3C, d);
        chk(d, 16'h0000);
        for (i = 0; i < 4; i++) begin
            wr(OFS_SELFTEST_CTRL, 16'(i) << 12);
            settle();
            chk({13'h0, gen_enable, gen_continuous, chk_enable}, {13'h0, i[0], i == 3, i[1]});
        end
        foreach (lb[k]) begin
            wr(OFS_SELFTEST_CTRL, {11'h0, lb[k]});
            settle();
            chk({11'h0, loop_select}, (lb[k] == 5'h03) ? 16'h0000 : {11'h0, lb[k]});
        end
        wr(OFS_SELFTEST_CTRL, 16'h0000);
        for (i = 0; i < 6; i++) begin
            r = $urandom;
            @(posedge sys_clk);
            {prbs_locked, prbs_sync_lost, gen_active, active_sleep} <= r[3:0];
            rd(OFS_SELFTEST_CTRL, d);
            chk(d, {4'h0, r[3:1], ~r[0], 8'h00});
        end
        @(posedge sys_clk);
        {prbs_locked, prbs_sync_lost, gen_active, active_sleep} <= 4'h0;
        mii_loopback <= 1'b1;
        speed_100 <= 1'b1;
        wr(OFS_SELFTEST_CTRL, 16'h0040);
        settle();
        chk({15'h0, tx_to_line}, 16'h0001);
        @(posedge sys_clk);
        speed_100 <= 1'b0;
        settle();
        chk({15'h0, tx_to_line}, 16'h0000);
        wr(OFS_SELFTEST_CTRL, 16'h0000);
        wr(OFS_IRQ_CLEAR, 16'h0007);
        wr(OFS_IRQ_ENABLE, 16'h0001);
        errs(10);
        rd(OFS_RX_ERR_COUNT, d);
        chk(d, 16'(rx_cnt));
        @(posedge sys_clk);
        mii_loopback <= 1'b0;
        slow <= 1'b1;
        n = 130 + $urandom % 100;
        errs(n);
        rd(OFS_RX_ERR_COUNT, d);
        chk(d, 16'(rx_cnt));
        rx_cnt = 0;
        chk({15'h0, irq}, 16'(half));
        rd(OFS_RX_ERR_COUNT, d);
        chk(d, 16'h0000);
        wr(OFS_IRQ_ENABLE, 16'h0000);
        settle();
        chk({15'h0, irq}, 16'h0000);
        wr(OFS_IRQ_CLEAR, 16'h0007);
        wr(OFS_IRQ_ENABLE, 16'h0001);
        settle();
        chk({15'h0, irq}, 16'h0000);
        @(posedge sys_clk);
        slow <= 1'b0;
        errs(300);
        rd(OFS_RX_ERR_COUNT, d);
        chk(d, 16'(rx_cnt));
        wr(OFS_SELFTEST_CTRL, 16'h2000);
        settle();
        chk({15'h0, chk_counting}, 16'h0001);
        perr(20);
        settle();
        chk({15'h0, chk_counting}, 16'h0000);
        wr(OFS_SELFTEST_CTRL, 16'h6000);
        n = pulses;
        perr(16);
        repeat (3) @(posedge sys_clk);
        #1 chk(16'(pulses - n), 16'h0001);
        chk({15'h0, chk_counting}, 16'h0001);
        rd(OFS_IRQ_STATUS, d);
        chk(d, 16'h0002 | 16'(half));
        summarize();
    end
endmodule // rx_err_selftest_test
`default_nettype wire
